// File: rtl/fvc_pkg.sv
// fvc_pkg: framing bytes, command codes, status codes and sizes
// for the flash verify command handler.
// assumes: byte-wide link, 24-bit flash addresses.
package fvc_pkg;
    // framing bytes
    localparam logic [7:0] SOH_BYTE       = 8'h01;
    localparam logic [7:0] STX_BYTE       = 8'h02;
    localparam logic [7:0] ETX_BYTE       = 8'h03;
    localparam logic [7:0] ETB_BYTE       = 8'h17;
    // command codes
    localparam logic [7:0] CMD_RESET      = 8'h00;
    localparam logic [7:0] CMD_VERIFY     = 8'h13;
    localparam logic [7:0] CMD_ERASE      = 8'h22;
    localparam logic [7:0] CMD_BLANK      = 8'h32;
    localparam logic [7:0] CMD_PROG       = 8'h40;
    localparam logic [7:0] CMD_SPROG      = 8'h41;
    localparam logic [7:0] CMD_BAUD       = 8'h9A;
    localparam logic [7:0] CMD_SECID      = 8'h9C;
    localparam logic [7:0] CMD_SSET       = 8'hA0;
    localparam logic [7:0] CMD_SGET       = 8'hA1;
    localparam logic [7:0] CMD_SREL       = 8'hA2;
    localparam logic [7:0] CMD_CSUM       = 8'hB0;
    localparam logic [7:0] CMD_SIG        = 8'hC0;
    // byte_count_field values
    localparam logic [7:0] LEN_RESET      = 8'h01;
    localparam logic [7:0] LEN_VERIFY     = 8'h07;
    localparam logic [7:0] LEN_DATA       = 8'h00;
    localparam logic [7:0] LEN_RSP_CMD    = 8'h01;
    localparam logic [7:0] LEN_RSP_DATA   = 8'h02;
    // reply_status_byte codes
    localparam logic [7:0] STS_CMD_ERR    = 8'h04;
    localparam logic [7:0] STS_PARAM_ERR  = 8'h05;
    localparam logic [7:0] STS_ACK        = 8'h06;
    localparam logic [7:0] STS_CSUM_ERR   = 8'h07;
    localparam logic [7:0] STS_VERIFY_ERR = 8'h0F;
    localparam logic [7:0] STS_NACK       = 8'h15;
    // sizes
    localparam int         ADDR_W         = 24;
    localparam int         DATA_BYTES     = 256;
    localparam int         ID_BIT         = 2;
endpackage

// File: rtl/fvc_reply_tx.sv
// fvc_reply_tx: sends one status reply packet, STX..ETX, one or
// two status bytes, check byte computed so the sum comes to zero.
// assumes: byte sink with valid/ready; go only while not busy.
module fvc_reply_tx (
    // clock and reset
    input  wire logic       sys_clk_in,
    input  wire logic       resetn_in,
    // request
    input  wire logic       go_in,
    input  wire logic [7:0] len_in,
    input  wire logic [7:0] sts1_in,
    input  wire logic [7:0] sts2_in,
    output logic            busy_out,
    // byte sink
    output logic [7:0]      tx_byte_out,
    output logic            tx_valid_out,
    input  wire logic       tx_ready_in
);
    logic [2:0] idx_r;
    logic [7:0] len_r;
    logic [7:0] s1_r;
    logic [7:0] s2_r;
    logic [7:0] chk;
    logic [2:0] last;

    assign chk  = 8'(8'h00 - len_r - s1_r
                     - ((len_r == fvc_pkg::LEN_RSP_DATA) ? s2_r : 8'h00));
    assign last = (len_r == fvc_pkg::LEN_RSP_DATA) ? 3'd5 : 3'd4;

    function automatic logic [7:0] pick(input logic [2:0] i,
                                        input logic       two,
                                        input logic [7:0] l,
                                        input logic [7:0] a,
                                        input logic [7:0] b,
                                        input logic [7:0] c);
        logic [7:0] v;
        v = fvc_pkg::ETX_BYTE;
        case (i)
            3'd0: v = fvc_pkg::STX_BYTE;
            3'd1: v = l;
            3'd2: v = a;
            3'd3: v = two ? b : c;
            3'd4: v = two ? c : fvc_pkg::ETX_BYTE;
            default: v = fvc_pkg::ETX_BYTE;
        endcase
        return v;
    endfunction

    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            idx_r        <= 3'd0;
            len_r        <= 8'h00;
            s1_r         <= 8'h00;
            s2_r         <= 8'h00;
            busy_out     <= 1'b0;
            tx_valid_out <= 1'b0;
            tx_byte_out  <= 8'h00;
        end else if (go_in && !busy_out) begin
            len_r        <= len_in;
            s1_r         <= sts1_in;
            s2_r         <= sts2_in;
            idx_r        <= 3'd0;
            busy_out     <= 1'b1;
            tx_valid_out <= 1'b1;
            tx_byte_out  <= fvc_pkg::STX_BYTE;
        end else if (busy_out && tx_ready_in) begin
            if (idx_r == last) begin
                busy_out     <= 1'b0;
                tx_valid_out <= 1'b0;
            end else begin
                idx_r       <= idx_r + 3'd1;
                tx_byte_out <= pick(idx_r + 3'd1,
                                    len_r == fvc_pkg::LEN_RSP_DATA,
                                    len_r, s1_r, s2_r, chk);
            end
        end
    end
endmodule

// File: rtl/fvc_top.sv
// fvc_top: device side of the serial programming Verify command,
// plus the Reset command answer, over a byte link and a flash read port.
// assumes: rx bytes arrive at least two clocks apart; flash data is
// valid one clock after flash_rd_out; host waits for every reply.
//
// Behaviour
// - Reset command in acceptance phase answered with ACK.
// - Missing ETX gives NACK, bad sum checksum error, forbidden command 04h.
// - Start address above end address gives parameter error.
// - Address outside both code and data flash gives parameter error.
// - Range crossing a code or data flash boundary gives parameter error.
// - Start not block first, or end not block last, parameter error.
// - Errors return to command wait; all checks pass then ACK sent.
// - One-status reply: STX, 01h, status, check byte, ETX.
// - While awaiting data, bytes other than STX are dropped.
// - Final data packet ending in neither ETX nor ETB gives NACK; ending in ETB is ACKed.
// - Non-final data packet without ETB gives NACK.
// - Data packet check byte wrong gives checksum error.
// - Data packet length field wrong gives NACK.
// - Data beyond range, or short at final packet, gives NACK.
// - Data packet error: error reply, abandon, back to command wait.
// - Good non-final packet: ACK, compare, keep taking packets.
// - Final packet compared, one overall reply, back to command wait.
// - Any mismatch remembered; verify error reported after last compare.
// - Data reply: 02h, communication then verification status, check byte, ETX.
// - Identifier data verifies until reset after readout bit cleared.
// - Length, payload and check byte sum to zero modulo 256.
// - Verification error status is 0Fh.
// - Parameter error status is 05h.
// - NACK status is 15h.
module fvc_top #(
    parameter logic [23:0] CODE_LAST   = 24'h03_FFFF,
    parameter logic [23:0] DATA_FIRST  = 24'hF1_000,
    parameter logic [23:0] DATA_LAST   = 24'hF2_FFF,
    parameter int          BLOCK_BYTES = 1024
) (
    // clock and reset
    input  wire logic        sys_clk_in,
    input  wire logic        resetn_in,
    // byte link from host
    input  wire logic [7:0]  rx_byte_in,
    input  wire logic        rx_valid_in,
    // byte link to host
    output logic [7:0]       tx_byte_out,
    output logic             tx_valid_out,
    input  wire logic        tx_ready_in,
    // phase and option byte
    input  wire logic        cmd_phase_in,
    input  wire logic [7:0]  option_byte_four_in,
    // flash read port
    output logic             flash_rd_out,
    output logic [23:0]      flash_addr_out,
    input  wire logic [7:0]  flash_data_in,
    input  wire logic        id_area_in,
    // status
    output logic             verify_busy_out
);
    localparam logic [23:0] BMASK = 24'(BLOCK_BYTES - 1);

    if (BLOCK_BYTES < fvc_pkg::DATA_BYTES ||
        (BLOCK_BYTES & (BLOCK_BYTES - 1)) != 0) begin : g_bad_block
        $error("BLOCK_BYTES must be a power of two, at least 256");
    end

    typedef enum logic [3:0] {
        S_IDLE, S_CLEN, S_CBODY, S_CSUM, S_CEND, S_RWAIT,
        S_DWAIT, S_DLEN, S_DBODY, S_DSUM, S_DEND
    } fvc_state_t;

    fvc_state_t  state_r;
    fvc_state_t  back_r;
    logic [7:0]  len_r;
    logic [7:0]  cmd_r;
    logic [7:0]  sum_r;
    logic [8:0]  idx_r;
    logic [8:0]  tot_r;
    logic [47:0] info_r;
    logic [23:0] sa;
    logic [23:0] ea;
    logic [24:0] rem_r;
    logic        over_r;
    logic        dlen_bad_r;
    logic        mismatch_r;
    logic [7:0]  exp_r;
    logic        cmp_pend_r;
    logic        id_hidden_r;
    logic        id_cap_r;
    logic        rsp_go_r;
    logic [7:0]  rsp_len_r;
    logic [7:0]  rsp_s1_r;
    logic [7:0]  rsp_s2_r;
    logic        tx_busy;
    logic        start_verify;
    logic [7:0]  cmd_sts;
    logic        cmd_reply;
    logic [7:0]  dat_sts;
    logic        byte_take;
    logic        sa_code;
    logic        sa_data;
    logic        ea_code;
    logic        ea_data;
    logic        cmd_known;

    assign sa        = info_r[23:0];
    assign ea        = info_r[47:24];
    assign byte_take = rx_valid_in;
    assign sa_code   = sa <= CODE_LAST;
    assign ea_code   = ea <= CODE_LAST;
    assign sa_data   = sa >= DATA_FIRST && sa <= DATA_LAST;
    assign ea_data   = ea >= DATA_FIRST && ea <= DATA_LAST;

    always_comb begin
        case (cmd_r)
            fvc_pkg::CMD_RESET, fvc_pkg::CMD_VERIFY, fvc_pkg::CMD_ERASE,
            fvc_pkg::CMD_BLANK, fvc_pkg::CMD_PROG, fvc_pkg::CMD_SPROG,
            fvc_pkg::CMD_SSET, fvc_pkg::CMD_SGET, fvc_pkg::CMD_SREL,
            fvc_pkg::CMD_CSUM, fvc_pkg::CMD_SIG: cmd_known = 1'b1;
            default: cmd_known = 1'b0;
        endcase
    end

    // command end: checks in the order the host sees them
    always_comb begin
        cmd_reply    = 1'b1;
        start_verify = 1'b0;
        cmd_sts      = fvc_pkg::STS_ACK;
        if (rx_byte_in != fvc_pkg::ETX_BYTE) begin
            cmd_sts = fvc_pkg::STS_NACK;
        end else if (sum_r != 8'h00) begin
            cmd_sts = fvc_pkg::STS_CSUM_ERR;
        end else if (!cmd_known || !cmd_phase_in) begin
            cmd_sts = fvc_pkg::STS_CMD_ERR;
        end else if (cmd_r != fvc_pkg::CMD_RESET &&
                     cmd_r != fvc_pkg::CMD_VERIFY) begin
            cmd_reply = 1'b0;
        end else if ((cmd_r == fvc_pkg::CMD_RESET &&
                      len_r != fvc_pkg::LEN_RESET) ||
                     (cmd_r == fvc_pkg::CMD_VERIFY &&
                      len_r != fvc_pkg::LEN_VERIFY)) begin
            cmd_sts = fvc_pkg::STS_NACK;
        end else if (cmd_r == fvc_pkg::CMD_RESET) begin
            cmd_sts = fvc_pkg::STS_ACK;
        end else if (sa > ea) begin
            cmd_sts = fvc_pkg::STS_PARAM_ERR;
        end else if (!(sa_code || sa_data) || !(ea_code || ea_data)) begin
            cmd_sts = fvc_pkg::STS_PARAM_ERR;
        end else if (sa_code != ea_code) begin
            cmd_sts = fvc_pkg::STS_PARAM_ERR;
        end else if ((sa & BMASK) != 24'h00_0000 ||
                     (ea & BMASK) != BMASK) begin
            cmd_sts = fvc_pkg::STS_PARAM_ERR;
        end else begin
            start_verify = 1'b1;
        end
    end

    // data packet end: terminator, check byte, length, count
    always_comb begin
        dat_sts = fvc_pkg::STS_ACK;
        if (rx_byte_in != fvc_pkg::ETX_BYTE &&
            rx_byte_in != fvc_pkg::ETB_BYTE) begin
            dat_sts = fvc_pkg::STS_NACK;
        end else if (sum_r != 8'h00) begin
            dat_sts = fvc_pkg::STS_CSUM_ERR;
        end else if (dlen_bad_r || over_r) begin
            dat_sts = fvc_pkg::STS_NACK;
        end else if (rx_byte_in == fvc_pkg::ETX_BYTE &&
                     rem_r != 25'd0) begin
            dat_sts = fvc_pkg::STS_NACK;
        end
    end

    // packet walk
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            state_r <= S_IDLE;
            back_r  <= S_IDLE;
        end else begin
            case (state_r)
                S_IDLE:  if (byte_take && rx_byte_in == fvc_pkg::SOH_BYTE)
                             state_r <= S_CLEN;
                S_CLEN:  if (byte_take) state_r <= S_CBODY;
                S_CBODY: if (byte_take && idx_r == tot_r - 9'd1)
                             state_r <= S_CSUM;
                S_CSUM:  if (byte_take) state_r <= S_CEND;
                S_CEND: begin
                    if (byte_take) begin
                        state_r <= cmd_reply ? S_RWAIT : S_IDLE;
                        back_r  <= start_verify ? S_DWAIT : S_IDLE;
                    end
                end
                S_RWAIT: if (!rsp_go_r && !tx_busy) state_r <= back_r;
                S_DWAIT: if (byte_take && rx_byte_in == fvc_pkg::STX_BYTE)
                             state_r <= S_DLEN;
                S_DLEN:  if (byte_take) state_r <= S_DBODY;
                S_DBODY: if (byte_take && idx_r == 9'd255)
                             state_r <= S_DSUM;
                S_DSUM:  if (byte_take) state_r <= S_DEND;
                S_DEND: begin
                    if (byte_take) begin
                        state_r <= S_RWAIT;
                        if (dat_sts == fvc_pkg::STS_ACK &&
                            rx_byte_in == fvc_pkg::ETB_BYTE)
                            back_r <= S_DWAIT;
                        else
                            back_r <= S_IDLE;
                    end
                end
                default: state_r <= S_IDLE;
            endcase
        end
    end

    // field capture and running check sum
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            len_r      <= 8'h00;
            cmd_r      <= 8'h00;
            sum_r      <= 8'h00;
            idx_r      <= 9'd0;
            tot_r      <= 9'd0;
            info_r     <= 48'h0000_0000_0000;
            dlen_bad_r <= 1'b0;
        end else if (byte_take) begin
            case (state_r)
                S_CLEN, S_DLEN: begin
                    len_r      <= rx_byte_in;
                    sum_r      <= rx_byte_in;
                    idx_r      <= 9'd0;
                    tot_r      <= (rx_byte_in == 8'h00) ? 9'd256
                                                        : {1'b0, rx_byte_in};
                    dlen_bad_r <= rx_byte_in != fvc_pkg::LEN_DATA;
                end
                S_CBODY, S_DBODY: begin
                    sum_r <= sum_r + rx_byte_in;
                    idx_r <= idx_r + 9'd1;
                    if (state_r == S_CBODY && idx_r == 9'd0)
                        cmd_r <= rx_byte_in;
                    else if (state_r == S_CBODY)
                        info_r <= {rx_byte_in, info_r[47:8]};
                end
                S_CSUM, S_DSUM: sum_r <= sum_r + rx_byte_in;
                default: sum_r <= sum_r;
            endcase
        end
    end

    // range bookkeeping and flash reads
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            rem_r          <= 25'd0;
            over_r         <= 1'b0;
            flash_rd_out   <= 1'b0;
            flash_addr_out <= 24'h00_0000;
            exp_r          <= 8'h00;
            cmp_pend_r     <= 1'b0;
        end else begin
            flash_rd_out <= 1'b0;
            cmp_pend_r   <= flash_rd_out;
            if (state_r == S_CEND && byte_take && start_verify) begin
                rem_r          <= 25'({1'b0, ea} - {1'b0, sa} + 25'd1);
                over_r         <= 1'b0;
                flash_addr_out <= sa;
            end else if (state_r == S_DBODY && byte_take) begin
                // bytes past the range set over_r, not compared
                if (rem_r == 25'd0) begin
                    over_r <= 1'b1;
                end else begin
                    rem_r        <= rem_r - 25'd1;
                    flash_rd_out <= 1'b1;
                    exp_r        <= rx_byte_in;
                end
            end
            if (flash_rd_out)
                flash_addr_out <= flash_addr_out + 24'h00_0001;
        end
    end

    // option byte caught once after reset release; a later clear of the
    // readout bit only takes effect through the next reset
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            id_cap_r    <= 1'b1;
            id_hidden_r <= 1'b0;
        end else if (id_cap_r) begin
            id_cap_r    <= 1'b0;
            id_hidden_r <= !option_byte_four_in[fvc_pkg::ID_BIT];
        end
    end

    // sticky mismatch over the whole range
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            mismatch_r <= 1'b0;
        end else if (cmp_pend_r && (flash_data_in != exp_r ||
                                    (id_area_in && id_hidden_r))) begin
            mismatch_r <= 1'b1;
        end else if (state_r == S_CEND && byte_take && start_verify) begin
            mismatch_r <= 1'b0;
        end
    end

    // reply requests
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            rsp_go_r  <= 1'b0;
            rsp_len_r <= 8'h00;
            rsp_s1_r  <= 8'h00;
            rsp_s2_r  <= 8'h00;
        end else begin
            rsp_go_r <= 1'b0;
            if (state_r == S_CEND && byte_take && cmd_reply) begin
                rsp_go_r  <= 1'b1;
                rsp_len_r <= fvc_pkg::LEN_RSP_CMD;
                rsp_s1_r  <= cmd_sts;
                rsp_s2_r  <= fvc_pkg::STS_ACK;
            end else if (state_r == S_DEND && byte_take) begin
                rsp_go_r  <= 1'b1;
                rsp_len_r <= fvc_pkg::LEN_RSP_DATA;
                rsp_s1_r  <= dat_sts;
                rsp_s2_r  <= (dat_sts == fvc_pkg::STS_ACK &&
                              rx_byte_in == fvc_pkg::ETX_BYTE &&
                              mismatch_r) ? fvc_pkg::STS_VERIFY_ERR
                                          : fvc_pkg::STS_ACK;
            end
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in)
            verify_busy_out <= 1'b0;
        else
            verify_busy_out <= state_r >= S_DWAIT ||
                               (state_r == S_RWAIT && back_r == S_DWAIT);
    end

    fvc_reply_tx u_reply (
        .sys_clk_in   (sys_clk_in),
        .resetn_in    (resetn_in),
        .go_in        (rsp_go_r),
        .len_in       (rsp_len_r),
        .sts1_in      (rsp_s1_r),
        .sts2_in      (rsp_s2_r),
        .busy_out     (tx_busy),
        .tx_byte_out  (tx_byte_out),
        .tx_valid_out (tx_valid_out),
        .tx_ready_in  (tx_ready_in)
    );

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!resetn_in);

    chk_reset_ack: assert property (
        state_r == S_CEND && byte_take && rx_byte_in == fvc_pkg::ETX_BYTE &&
        sum_r == 8'h00 && cmd_phase_in && cmd_r == fvc_pkg::CMD_RESET &&
        len_r == fvc_pkg::LEN_RESET
        |=> rsp_go_r && rsp_s1_r == fvc_pkg::STS_ACK &&
            rsp_len_r == fvc_pkg::LEN_RSP_CMD ##1 state_r == S_RWAIT)
        else $error("reset command not acknowledged");
    chk_cmd_etx_nack: assert property (
        state_r == S_CEND && byte_take && rx_byte_in != fvc_pkg::ETX_BYTE
        |=> rsp_go_r && rsp_s1_r == fvc_pkg::STS_NACK ##[1:40]
            state_r == S_IDLE)
        else $error("missing command ETX not answered with NACK");
    chk_param_order: assert property (
        state_r == S_CEND && byte_take && rx_byte_in == fvc_pkg::ETX_BYTE &&
        sum_r == 8'h00 && cmd_phase_in && cmd_r == fvc_pkg::CMD_VERIFY &&
        len_r == fvc_pkg::LEN_VERIFY && sa > ea
        |=> rsp_go_r && rsp_s1_r == 8'h05 && back_r == S_IDLE)
        else $error("start above end not refused");
    chk_param_reply: assert property (
        state_r == S_CEND && byte_take && cmd_sts == fvc_pkg::STS_PARAM_ERR
        |=> rsp_s1_r == 8'h05 && back_r == S_IDLE)
        else $error("parameter error not reported or not abandoned");
    chk_stx_hunt: assert property (
        state_r == S_DWAIT && byte_take && rx_byte_in != fvc_pkg::STX_BYTE
        |=> state_r == S_DWAIT && !rsp_go_r)
        else $error("non-STX byte left the data wait");
    chk_good_packet: assert property (
        state_r == S_DEND && byte_take && dat_sts == fvc_pkg::STS_ACK &&
        rx_byte_in == fvc_pkg::ETB_BYTE
        |=> rsp_s1_r == 8'h06 && rsp_s2_r == 8'h06 && back_r == S_DWAIT)
        else $error("good data packet not acknowledged");
    chk_short_final: assert property (
        state_r == S_DEND && byte_take && rx_byte_in == fvc_pkg::ETX_BYTE &&
        rem_r != 25'd0 && sum_r == 8'h00
        |=> rsp_s1_r == 8'h15 && back_r == S_IDLE)
        else $error("short final data not answered with NACK");
    chk_mismatch_hold: assert property (
        mismatch_r && !(state_r == S_CEND && byte_take)
        |=> mismatch_r)
        else $error("mismatch memory lost within a verify");
    chk_final_verr: assert property (
        state_r == S_DEND && byte_take && dat_sts == fvc_pkg::STS_ACK &&
        rx_byte_in == fvc_pkg::ETX_BYTE && mismatch_r
        |=> rsp_s2_r == 8'h0F ##1 state_r == S_RWAIT && back_r == S_IDLE)
        else $error("final mismatch not reported");
endmodule

// File: sim/fvc_host_model.sv
// fvc_host_model: host end of the byte link, sends and takes bytes.
// assumes: one clock shared with the device; caller spaces packets.
module fvc_host_model (
    input  wire logic       clk_in,
    output logic [7:0]      rx_byte_out,
    output logic            rx_valid_out,
    input  wire logic [7:0] tx_byte_in,
    input  wire logic       tx_valid_in,
    output logic            tx_ready_out
);
    timeunit 1ns;
    timeprecision 1ns;
    bit slow = 0;
    initial begin
        rx_byte_out = 8'h00;
        rx_valid_out = 1'h0;
        tx_ready_out = 1'h1;
    end
    // one clock valid, then one idle: keeps bytes two clocks apart
    task put(input logic [7:0] b);
        @(posedge clk_in);
        #1 rx_byte_out = b;
        rx_valid_out = 1'h1;
        @(posedge clk_in);
        #1 rx_valid_out = 1'h0;
        rx_byte_out = ~b;
    endtask
    task get(output logic [7:0] b);
        b = 'x;
        if (slow) begin
            #1 tx_ready_out = 1'h0;
            repeat (2) @(posedge clk_in);
            #1 tx_ready_out = 1'h1;
        end
        for (int n = 0; n < 600; n++) begin
            @(posedge clk_in);
            if (tx_valid_in === 1'h1) begin
                b = tx_byte_in;
                break;
            end
        end
    endtask
endmodule

// File: sim/flash_verify_command_handler_bench.sv
// flash_verify_command_handler_bench: random and corner Verify runs.
// assumes: fvc_top defaults, flash model returns fm(address).
module flash_verify_command_handler_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 0, rstn = 0, rd, tv, rv, tr, vb, ida = 0, ph = 1;
    logic [7:0]  rb, tb, fd = 8'h00, ob = 8'h04;
    logic [23:0] fa;
    logic [31:0] seed = 32'h0000_42e0;
    int          bad_count = 0, n_checks = 0, cyc = 0;
    always #50 clk = ~clk;
    fvc_host_model i_fvc_host_model (.clk_in(clk), .rx_byte_out(rb),
        .rx_valid_out(rv), .tx_byte_in(tb), .tx_valid_in(tv),
        .tx_ready_out(tr));
    fvc_top i_fvc_top (.sys_clk_in(clk), .resetn_in(rstn), .rx_byte_in(rb),
        .rx_valid_in(rv), .tx_byte_out(tb), .tx_valid_out(tv),
        .tx_ready_in(tr), .cmd_phase_in(ph), .option_byte_four_in(ob),
        .flash_rd_out(rd), .flash_addr_out(fa), .flash_data_in(fd),
        .id_area_in(ida), .verify_busy_out(vb));
    function logic [7:0] fm(input logic [23:0] a);
        return a[7:0] ^ a[15:8] ^ 8'hA5;
    endfunction
    function logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    always @(posedge clk) if (rd) fd <= fm(fa);
    always @(posedge clk) if (++cyc == 20000) begin
        bad_count++;
        conclude();
    end
    task conclude();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task chk(input logic [7:0] s, input logic [7:0] e);
        n_checks++;
        if (s !== e) begin
            bad_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    // frame with sum-to-zero check byte; sx corrupts it on purpose
    task send(input logic [7:0] h, input logic [7:0] q[$],
              input logic [7:0] t, input logic [7:0] sx);
        logic [7:0] cs;
        cs = 8'h00;
        foreach (q[i]) cs -= q[i];
        q.push_back(cs ^ sx);
        q.push_front(h);
        q.push_back(t);
        foreach (q[i]) i_fvc_host_model.put(q[i]);
    endtask
    task vcmd(input logic [23:0] s, input logic [23:0] e,
              input logic [7:0] t);
        send(8'h01, {8'h07, 8'h13, s[7:0], s[15:8], s[23:16], e[7:0],
                     e[15:8], e[23:16]}, t, 8'h00);
    endtask
    task dpk(input logic [23:0] a, input int bad, input logic [7:0] t,
             input logic [7:0] sx);
        logic [7:0] q[$];
        q = {8'h00};
        for (int i = 0; i < 256; i++)
            q.push_back(fm(a + 24'(i)) ^ {7'h00, i == bad});
        send(8'h02, q, t, sx);
    endtask
    task rsp(input logic [7:0] n, input logic [7:0] s1,
             input logic [7:0] s2);
        logic [7:0] b, q[$];
        q = {8'h02, n, s1};
        if (n == 8'h02) q.push_back(s2);
        q.push_back(8'h00 - n - s1 - (n == 8'h02 ? s2 : 8'h00));
        q.push_back(8'h03);
        foreach (q[i]) begin
            i_fvc_host_model.get(b);
            chk(b, q[i]);
        end
    endtask
    // one block, four packets; junk ahead of the first packet
    task run(input int pkt, input int bad, input logic [7:0] s2);
        vcmd(24'h00_0400, 24'h00_07FF, 8'h03);
        rsp(8'h01, 8'h06, 8'h00);
        i_fvc_host_model.put(8'(xs()) | 8'h80);
        chk({7'h00, vb}, 8'h01);
        for (int p = 0; p < 4; p++) begin
            dpk(24'h00_0400 + 24'(256 * p), p == pkt ? bad : -1,
                p == 3 ? 8'h03 : 8'h17, 8'h00);
            if (p < 3) rsp(8'h02, 8'h06, 8'h06);
        end
        rsp(8'h02, 8'h06, s2);
        chk({7'h00, vb}, 8'h00);
    endtask
    logic [23:0] pr[8] = '{24'h00_0800, 24'h00_07FF, 24'h05_0000, 24'h05_03FF,
        24'h03_FC00, 24'h0F_13FF, 24'h00_0401, 24'h00_07FF};
    initial begin
        repeat (20) @(posedge clk);
        #1 rstn = 1;
        send(8'h01, {8'h01, 8'h00}, 8'h03, 8'h00);
        rsp(8'h01, 8'h06, 8'h00);
        send(8'h01, {8'h01, 8'h9A}, 8'h03, 8'h00);
        rsp(8'h01, 8'h04, 8'h00);
        #1 ph = 0;
        send(8'h01, {8'h01, 8'h00}, 8'h03, 8'h01);
        rsp(8'h01, 8'h07, 8'h00);
        send(8'h01, {8'h01, 8'h00}, 8'h03, 8'h00);
        rsp(8'h01, 8'h04, 8'h00);
        #1 ph = 1;
        for (int k = 0; k < 8; k += 2) begin
            vcmd(pr[k], pr[k+1], 8'h03);
            rsp(8'h01, 8'h05, 8'h00);
        end
        vcmd(24'h00_0400, 24'h00_07FF, 8'h17);
        rsp(8'h01, 8'h15, 8'h00);
        $display("command checks done");
        // readout bit cleared after capture: identifier data still matches
        #1 ob = 8'h00;
        ida = 1;
        run(-1, 0, 8'h06);
        i_fvc_host_model.slow = 1;
        run(int'(xs() % 4), int'(xs() % 256), 8'h0F);
        $display("verify runs done");
        vcmd(24'h00_0400, 24'h00_07FF, 8'h03);
        rsp(8'h01, 8'h06, 8'h00);
        dpk(24'h00_0400, -1, 8'h17, 8'h01);
        rsp(8'h02, 8'h07, 8'h06);
        vcmd(24'h00_0400, 24'h00_07FF, 8'h03);
        rsp(8'h01, 8'h06, 8'h00);
        dpk(24'h00_0400, -1, 8'h03, 8'h00);
        rsp(8'h02, 8'h15, 8'h06);
        $display("data errors done");
        // reset with the bit still clear: identifier data now mismatches
        @(posedge clk);
        #1 rstn = 0;
        repeat (2) @(posedge clk);
        #1 rstn = 1;
        run(-1, 0, 8'h0F);
        $display("identifier checks done");
        conclude();
    end
endmodule
